// ---- rtl/ads_params.svh ----
/*
  constants of the audio delay serial control block: frame layout, id codes,
  defaults, timing counts and register offsets.
  assumes it is included by its bare name, after nothing else.
*/
`ifndef ADS_PARAMS_SVH
`define ADS_PARAMS_SVH

// frame layout, msb shifted first
`define ADS_FRAME_BITS    12
`define ADS_ADDR_MSB      11
`define ADS_ADDR_LSB      8
`define ADS_SLEEP_BIT     7
`define ADS_DELAY_MSB     6
`define ADS_DELAY_LSB     1
`define ADS_MUTE_BIT      0

// id codes picked by the address select pin
`define ADS_ID_LOW        4'h2
`define ADS_ID_HIGH       4'h3

// power-on default: code for 20.0 ms
`define ADS_DELAY_DEFAULT 6'h26
`define ADS_RB_BITS       4'h8

// clocking
`define ADS_CLK_KHZ       25000
`define ADS_MCLK_KHZ      2000
`define ADS_FS_DIV_LAST   2'h3
`define ADS_STEP_SHIFT    8
`define ADS_POR_TIME_MS   120
`define ADS_POR_CYCLES    (`ADS_POR_TIME_MS * `ADS_CLK_KHZ)

// register offsets and values
`define ADS_REG_STATUS    4'h0
`define ADS_REG_CONTROL   4'h4
`define ADS_REG_DELAY     4'h8
`define ADS_REG_POINTERS  4'hC
`define ADS_CONTROL_RESET 1'h0
`define ADS_RESP_OKAY     2'h0
`define ADS_RESP_SLVERR   2'h2

`endif

// ---- rtl/ads_pkg.sv ----
/*
  types of the audio delay serial control block.
  assumes nothing beyond a systemverilog compiler.
*/
package ads_pkg;

  typedef enum logic [2:0] {
    ADS_RB_IDLE  = 3'b001,
    ADS_RB_ACK   = 3'b010,
    ADS_RB_SHIFT = 3'b100
  } ads_rb_state_t;

endpackage : ads_pkg

// ---- rtl/ads_serial_ctrl.sv ----
/*
  serial control of the audio delay device: frame receiver, id match,
  settings, acknowledge/readback, power-on init, sample timing, pointer
  generation and an axi4-lite register slave.
  assumes aclk at 25 MHz, serial pins asynchronous to aclk, shift clock
  well below aclk/4, and an outside memory that uses the pointers.
*/
// Our own choices: register access over AXI4-Lite and the placing of the registers.
`include "ads_params.svh"

module ads_serial_ctrl #(
  parameter int POR_CYCLES = `ADS_POR_CYCLES
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write
  input  wire logic [3:0]  awaddr,
  input  wire logic        awvalid,
  output      logic        awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output      logic        wready,
  output      logic [1:0]  bresp,
  output      logic        bvalid,
  input  wire logic        bready,
  // axi4-lite read
  input  wire logic [3:0]  araddr,
  input  wire logic        arvalid,
  output      logic        arready,
  output      logic [31:0] rdata,
  output      logic [1:0]  rresp,
  output      logic        rvalid,
  input  wire logic        rready,
  // serial pins
  input  wire logic        shift_clk,
  input  wire logic        serial_data,
  input  wire logic        latch_req,
  input  wire logic        address_select_pin,
  output      logic        ack_readback_pin,
  // audio core side
  output      logic        mute_out,
  output      logic        sleep_out,
  output      logic        core_clk_run,
  output      logic        sample_tick,
  output      logic [5:0]  delay_select_bits,
  output      logic [13:0] mem_wr_addr,
  output      logic [13:0] mem_rd_addr,
  output      logic        por_busy
);

  // pin synchronisers; stage one is read only by stage two
  logic [3:0] sync1, sync2;
  logic [1:0] prev;
  logic       sck_s, sdata_s, req_s, idsel_s;
  logic       sck_fall, sck_rise, req_rise;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
      prev  <= 2'h0;
    end else begin
      sync1 <= {address_select_pin, latch_req, serial_data, shift_clk};
      sync2 <= sync1;
      prev  <= {sync2[2], sync2[0]};
    end
  end
  assign {idsel_s, req_s, sdata_s, sck_s} = sync2;
  assign sck_fall = prev[0] & ~sck_s;
  assign sck_rise = ~prev[0] & sck_s;
  assign req_rise = ~prev[1] & req_s;

  // power-on hold
  logic [21:0] por_cnt, next_por_cnt;
  logic        next_por_busy;
  always_comb begin
    next_por_cnt  = por_cnt;
    next_por_busy = por_busy;
    if (por_busy && por_cnt >= POR_CYCLES[21:0] - 22'h1) begin
      next_por_busy = 1'b0;
    end else if (por_busy) begin
      next_por_cnt = por_cnt + 22'h1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      por_cnt  <= 22'h0;
      por_busy <= 1'b1;
    end else begin
      por_cnt  <= next_por_cnt;
      por_busy <= next_por_busy;
    end
  end

  // frame receiver and settings
  logic [11:0] frame, next_frame;
  logic        shifted, next_shifted, sleep_q, mute_q, next_sleep, next_mute;
  logic [5:0]  delay_q, next_delay;
  logic [3:0]  own_id;
  logic        latch_now, accept, reject;
  assign own_id    = idsel_s ? `ADS_ID_HIGH : `ADS_ID_LOW;
  // a bit shifted in while the strobe is high is acted on one cycle later
  assign latch_now = req_rise | (req_s & shifted);
  assign accept    = latch_now & ~por_busy & (frame[`ADS_ADDR_MSB:`ADS_ADDR_LSB] == own_id);
  assign reject    = req_rise & ~accept;
  always_comb begin
    next_frame   = frame;
    next_shifted = sck_fall;
    next_sleep   = sleep_q;
    next_mute    = mute_q;
    next_delay   = delay_q;
    if (sck_fall)
      next_frame = {frame[10:0], sdata_s};
    if (por_busy) begin
      next_sleep = 1'b0;
      next_mute  = 1'b0;
      next_delay = `ADS_DELAY_DEFAULT;
    end else if (accept) begin
      next_sleep = frame[`ADS_SLEEP_BIT];
      next_mute  = frame[`ADS_MUTE_BIT];
      next_delay = frame[`ADS_DELAY_MSB:`ADS_DELAY_LSB];
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame   <= 12'h000;
      shifted <= 1'b0;
      sleep_q <= 1'b0;
      mute_q  <= 1'b0;
      delay_q <= `ADS_DELAY_DEFAULT;
    end else begin
      frame   <= next_frame;
      shifted <= next_shifted;
      sleep_q <= next_sleep;
      mute_q  <= next_mute;
      delay_q <= next_delay;
    end
  end

  // acknowledge and readback
  ads_pkg::ads_rb_state_t rb_state, next_rb_state;
  logic [7:0]             rb_shift, next_rb_shift;
  logic [3:0]             rb_cnt, next_rb_cnt;
  logic                   next_ack;
  always_comb begin
    next_rb_state = rb_state;
    next_rb_shift = rb_shift;
    next_rb_cnt   = rb_cnt;
    next_ack      = ack_readback_pin;
    if (accept) begin
      next_rb_state = ads_pkg::ADS_RB_ACK;
      next_rb_shift = {frame[`ADS_SLEEP_BIT], frame[`ADS_DELAY_MSB:`ADS_DELAY_LSB], frame[`ADS_MUTE_BIT]};
      next_rb_cnt   = 4'h0;
      next_ack      = 1'b1;
    end else if (reject) begin
      next_rb_state = ads_pkg::ADS_RB_IDLE;
      next_ack      = 1'b0;
    end else begin
      case (rb_state)
        ads_pkg::ADS_RB_IDLE: next_ack = 1'b0;
        ads_pkg::ADS_RB_ACK, ads_pkg::ADS_RB_SHIFT: begin
          if (sck_rise && !req_s) begin
            if (rb_cnt == `ADS_RB_BITS) begin
              next_rb_state = ads_pkg::ADS_RB_IDLE;
              next_ack      = 1'b0;
            end else begin
              next_rb_state = ads_pkg::ADS_RB_SHIFT;
              next_ack      = rb_shift[7];
              next_rb_shift = {rb_shift[6:0], 1'b0};
              next_rb_cnt   = rb_cnt + 4'h1;
            end
          end
        end
        default: begin
          next_rb_state = ads_pkg::ADS_RB_IDLE;
          next_ack      = 1'b0;
        end
      endcase
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rb_state         <= ads_pkg::ADS_RB_IDLE;
      rb_shift         <= 8'h00;
      rb_cnt           <= 4'h0;
      ack_readback_pin <= 1'b0;
    end else begin
      rb_state         <= next_rb_state;
      rb_shift         <= next_rb_shift;
      rb_cnt           <= next_rb_cnt;
      ack_readback_pin <= next_ack;
    end
  end

  // master clock and sample rate; the fractional accumulator gives 2 MHz on
  // average from 25 MHz, at the cost of one cycle of jitter per tick
  logic [15:0] phase, next_phase, phase_sum;
  logic [1:0]  fs_cnt, next_fs_cnt;
  logic        next_sample_tick, control_mute;
  logic [13:0] wptr, next_wptr;
  logic [14:0] delay_samples;
  assign phase_sum     = phase + 16'(`ADS_MCLK_KHZ);
  assign core_clk_run  = ~sleep_q & ~por_busy;
  // (code + 1) * 256 samples
  assign delay_samples = {1'b0, delay_q, 8'h00} + 15'h0100;
  always_comb begin
    next_phase       = phase;
    next_fs_cnt      = fs_cnt;
    next_sample_tick = 1'b0;
    next_wptr        = wptr;
    if (core_clk_run) begin
      if (phase_sum >= 16'(`ADS_CLK_KHZ)) begin
        next_phase  = phase_sum - 16'(`ADS_CLK_KHZ);
        next_fs_cnt = fs_cnt + 2'h1;
        if (fs_cnt == `ADS_FS_DIV_LAST) begin
          next_sample_tick = 1'b1;
          next_wptr        = wptr + 14'h0001;
        end
      end else begin
        next_phase = phase_sum;
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase       <= 16'h0000;
      fs_cnt      <= 2'h0;
      sample_tick <= 1'b0;
      wptr        <= 14'h0000;
    end else begin
      phase       <= next_phase;
      fs_cnt      <= next_fs_cnt;
      sample_tick <= next_sample_tick;
      wptr        <= next_wptr;
    end
  end

  assign mem_wr_addr       = wptr;
  // code 63 wraps to a full buffer: read the oldest word just before overwrite
  assign mem_rd_addr       = wptr - delay_samples[13:0];
  assign delay_select_bits = delay_q;
  assign sleep_out         = sleep_q;
  assign mute_out          = mute_q | sleep_q | por_busy | control_mute;

  // axi4-lite slave
  logic        aw_held, next_aw_held, w_held, next_w_held, next_bvalid, next_rvalid, next_control_mute;
  logic [3:0]  aw_addr_q, next_aw_addr, w_strb_q, next_w_strb;
  logic [31:0] w_data_q, next_w_data, next_rdata;
  logic [1:0]  next_bresp, next_rresp;
  assign awready = ~aw_held & ~bvalid;
  assign wready  = ~w_held & ~bvalid;
  assign arready = ~rvalid;
  always_comb begin
    next_aw_held      = aw_held;
    next_aw_addr      = aw_addr_q;
    next_w_held       = w_held;
    next_w_data       = w_data_q;
    next_w_strb       = w_strb_q;
    next_bvalid       = bvalid;
    next_bresp        = bresp;
    next_rvalid       = rvalid;
    next_rdata        = rdata;
    next_rresp        = rresp;
    next_control_mute = control_mute;
    if (awvalid && awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_w_held = 1'b1;
      next_w_data = wdata;
      next_w_strb = wstrb;
    end
    if (bvalid && bready)
      next_bvalid = 1'b0;
    if (next_aw_held && next_w_held && !bvalid) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = `ADS_RESP_OKAY;
      if (next_aw_addr == `ADS_REG_CONTROL) begin
        if (next_w_strb[0])
          next_control_mute = next_w_data[0];
      end else if (next_aw_addr != `ADS_REG_STATUS && next_aw_addr != `ADS_REG_DELAY &&
                   next_aw_addr != `ADS_REG_POINTERS) begin
        next_bresp = `ADS_RESP_SLVERR;
      end
    end
    if (rvalid && rready)
      next_rvalid = 1'b0;
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rresp  = `ADS_RESP_OKAY;
      case (araddr)
        `ADS_REG_STATUS: begin
          next_rdata = {21'h000000, rb_state == ads_pkg::ADS_RB_SHIFT, por_busy, ack_readback_pin,
                        sleep_q, delay_q, mute_q};
        end
        `ADS_REG_CONTROL: begin
          next_rdata = {31'h00000000, control_mute};
        end
        `ADS_REG_DELAY: begin
          next_rdata = {17'h00000, delay_samples};
        end
        `ADS_REG_POINTERS: begin
          next_rdata = {2'h0, mem_rd_addr, 2'h0, wptr};
        end
        default: begin
          next_rdata = 32'h00000000;
          next_rresp = `ADS_RESP_SLVERR;
        end
      endcase
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held      <= 1'b0;
      aw_addr_q    <= 4'h0;
      w_held       <= 1'b0;
      w_data_q     <= 32'h00000000;
      w_strb_q     <= 4'h0;
      bvalid       <= 1'b0;
      bresp        <= 2'h0;
      rvalid       <= 1'b0;
      rdata        <= 32'h00000000;
      rresp        <= 2'h0;
      control_mute <= `ADS_CONTROL_RESET;
    end else begin
      aw_held      <= next_aw_held;
      aw_addr_q    <= next_aw_addr;
      w_held       <= next_w_held;
      w_data_q     <= next_w_data;
      w_strb_q     <= next_w_strb;
      bvalid       <= next_bvalid;
      bresp        <= next_bresp;
      rvalid       <= next_rvalid;
      rdata        <= next_rdata;
      rresp        <= next_rresp;
      control_mute <= next_control_mute;
    end
  end

endmodule : ads_serial_ctrl

// ---- verification/ads_serial_ctrl_props.sv ----
/* assertions on the ports of the serial control block.
   assumes ads_params.svh on the include path; bound below to every instance. */
`include "ads_params.svh"
module ads_serial_ctrl_props (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // serial and core side
  input wire logic        latch_req,
  input wire logic        ack_readback_pin,
  input wire logic        mute_out,
  input wire logic        sleep_out,
  input wire logic        core_clk_run,
  input wire logic        sample_tick,
  input wire logic [5:0]  delay_select_bits,
  input wire logic [13:0] mem_wr_addr,
  input wire logic [13:0] mem_rd_addr,
  input wire logic        por_busy
);
  logic [3:0] since_latch;
  logic [3:0] next_since_latch;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // the delay setting may only move a few cycles after the strobe pin was high
  always_comb begin
    next_since_latch = since_latch;
    if (latch_req)
      next_since_latch = 4'h0;
    else if (since_latch != 4'hF)
      next_since_latch = since_latch + 4'h1;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn)
      since_latch <= 4'hF;
    else
      since_latch <= next_since_latch;
  end
  sequence tick_gap_s; !sample_tick [*8]; endsequence
  sequence next_tick_s; ##[46:54] (sample_tick || sleep_out || por_busy); endsequence
  por_default_a: assert property (por_busy |-> delay_select_bits == `ADS_DELAY_DEFAULT && mute_out && !core_clk_run)
    else $error("power-on settings wrong");
  por_no_ack_a: assert property (por_busy |-> !ack_readback_pin)
    else $error("ack during power-on hold");
  sleep_mute_a: assert property (sleep_out |-> mute_out && !core_clk_run)
    else $error("sleep without mute or clock stop");
  sleep_hold_a: assert property (sleep_out && $past(sleep_out) && $past(sleep_out, 2) |-> !sample_tick && $stable(mem_wr_addr))
    else $error("memory moves in sleep");
  tick_pulse_a: assert property (sample_tick |=> tick_gap_s)
    else $error("sample tick too close");
  tick_period_a: assert property (sample_tick |-> next_tick_s)
    else $error("sample tick period wrong");
  wr_step_a: assert property (sample_tick |-> mem_wr_addr == $past(mem_wr_addr) + 14'h1)
    else $error("write pointer step wrong");
  rd_offset_a: assert property (mem_rd_addr == mem_wr_addr - {delay_select_bits + 6'h1, 8'h00})
    else $error("read pointer offset wrong");
  settings_hold_a: assert property ($changed(delay_select_bits) |-> por_busy || since_latch < 4'h8)
    else $error("delay changed without a frame");
endmodule : ads_serial_ctrl_props
bind ads_serial_ctrl ads_serial_ctrl_props i_ads_serial_ctrl_props (.aclk(aclk), .aresetn(aresetn),
  .latch_req(latch_req), .ack_readback_pin(ack_readback_pin), .mute_out(mute_out), .sleep_out(sleep_out),
  .core_clk_run(core_clk_run), .sample_tick(sample_tick), .delay_select_bits(delay_select_bits),
  .mem_wr_addr(mem_wr_addr), .mem_rd_addr(mem_rd_addr), .por_busy(por_busy));

// ---- verification/ads_host_model.sv ----
/* host controller on the serial pins: shifts frames, strobes, reads back.
   assumes aclk is the bench clock; the shift clock is far below aclk/4. */
module ads_host_model (
  // clock
  input wire logic aclk,
  // serial pins
  output logic     shift_clk,
  output logic     serial_data,
  output logic     latch_req,
  input wire logic ack_readback_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    shift_clk = 1'b0;
    serial_data = 1'b0;
    latch_req = 1'b0;
  end
  // data set at the rising edge is stable at the falling edge that shifts it
  task shift(input logic [15:0] v, input int n);
    for (int i = 15; i > 15 - n; i--) begin
      @(posedge aclk);
      serial_data <= v[i];
      shift_clk <= 1'b1;
      repeat (8) @(posedge aclk);
      shift_clk <= 1'b0;
      repeat (8) @(posedge aclk);
    end
  endtask : shift // clock parked low, data held after the frame
  task latch(input logic b);
    @(posedge aclk);
    latch_req <= b;
    repeat (8) @(posedge aclk);
  endtask : latch
  task read_back(output logic [8:0] v); // strobe stays low
    for (int i = 8; i >= 0; i--) begin
      @(posedge aclk);
      shift_clk <= 1'b1;
      repeat (8) @(negedge aclk);
      v[i] = ack_readback_pin;
      @(posedge aclk);
      shift_clk <= 1'b0;
      repeat (8) @(posedge aclk);
    end
  endtask : read_back
endmodule : ads_host_model

// ---- verification/audio_delay_serial_control_test.sv ----
/* self-checking bench of the serial control block with a host model.
   assumes ads_params.svh on the include path and the props file bound. */
`include "ads_params.svh"
module audio_delay_serial_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int POR = 20;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, address_select_pin;
  logic [3:0]  awaddr, wstrb, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0]  bresp, rresp, r;
  logic        awready, wready, bvalid, arready, rvalid, shift_clk, serial_data, latch_req;
  logic        ack_readback_pin, mute_out, sleep_out, core_clk_run, sample_tick, por_busy;
  logic [5:0]  delay_select_bits;
  logic [13:0] mem_wr_addr, mem_rd_addr, w;
  logic [8:0]  rb;
  int          n_mismatch, n_compared, n;
  ads_serial_ctrl #(.POR_CYCLES(POR)) i_ads_serial_ctrl (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .shift_clk(shift_clk),
    .serial_data(serial_data), .latch_req(latch_req), .address_select_pin(address_select_pin),
    .ack_readback_pin(ack_readback_pin), .mute_out(mute_out), .sleep_out(sleep_out),
    .core_clk_run(core_clk_run), .sample_tick(sample_tick), .delay_select_bits(delay_select_bits),
    .mem_wr_addr(mem_wr_addr), .mem_rd_addr(mem_rd_addr), .por_busy(por_busy));
  ads_host_model i_ads_host_model (.aclk(aclk), .shift_clk(shift_clk), .serial_data(serial_data),
    .latch_req(latch_req), .ack_readback_pin(ack_readback_pin));
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  task test_done;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : test_done
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // ready is looked at mid-cycle, where it equals its value at the next edge
  task axi_wr(input logic [3:0] a, input logic [31:0] v);
    logic ha, hw, hb;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    hb = 1'b0;
    while (!hb) begin
      @(negedge aclk);
      ha = awready;
      hw = wready;
      hb = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      if (hb) bready <= 1'b0;
    end
  endtask : axi_wr
  task axi_rd(input logic [3:0] a);
    logic ha, hr;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    hr = 1'b0;
    while (!hr) begin
      @(negedge aclk);
      ha = arready;
      hr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ha) arvalid <= 1'b0;
      if (hr) rready <= 1'b0;
    end
  endtask : axi_rd
  // four junk bits lead every frame; only the last twelve may count
  task send(input logic [3:0] id, input logic sl, input logic [5:0] c, input logic mu);
    i_ads_host_model.shift({4'hF, id, sl, c, mu}, 16);
    i_ads_host_model.latch(1'b1);
    i_ads_host_model.latch(1'b0);
    @(negedge aclk);
  endtask : send
  task t_defaults;
    @(negedge aclk);
    chk(delay_select_bits, `ADS_DELAY_DEFAULT);
    chk(mute_out, 1'b1);
    n = 0;
    while (por_busy === 1'b1 && n < 100) begin
      @(negedge aclk);
      n++;
    end
    chk(n >= POR - 2 && n <= POR + 1, 1'b1);
    chk({mute_out, core_clk_run}, 2'h1);
    $display("t_defaults done");
  endtask : t_defaults
  task t_ids;
    logic [3:0] own, oth;
    logic [5:0] c;
    for (int s = 0; s < 2; s++) begin
      own = s ? `ADS_ID_HIGH : `ADS_ID_LOW;
      oth = s ? `ADS_ID_LOW : `ADS_ID_HIGH;
      c = s ? 6'h3F : 6'h00;
      @(posedge aclk);
      address_select_pin <= s[0];
      send(own, 1'b0, c, 1'b0);
      chk({ack_readback_pin, delay_select_bits}, {1'b1, c});
      send(oth, 1'b1, ~c, 1'b1);
      chk({ack_readback_pin, mute_out, delay_select_bits}, {2'h0, c});
    end
    $display("t_ids done");
  endtask : t_ids
  task t_sleep;
    send(`ADS_ID_HIGH, 1'b1, 6'h10, 1'b0);
    chk({sleep_out, mute_out, core_clk_run}, 3'h6);
    w = mem_wr_addr;
    repeat (120) @(negedge aclk);
    chk(mem_wr_addr, w);
    send(`ADS_ID_HIGH, 1'b0, 6'h10, 1'b1); // muted while leaving sleep
    chk({sleep_out, mute_out, core_clk_run}, 3'h3);
    repeat (120) @(negedge aclk);
    chk(mem_wr_addr !== w, 1'b1);
    send(`ADS_ID_HIGH, 1'b0, 6'h10, 1'b0);
    chk(mute_out, 1'b0);
    $display("t_sleep done");
  endtask : t_sleep
  task t_readback;
    send(`ADS_ID_HIGH, 1'b0, 6'h2D, 1'b1);
    i_ads_host_model.read_back(rb);
    chk(rb, {1'b0, 6'h2D, 1'b1, 1'b0});
    @(negedge aclk);
    chk(ack_readback_pin, 1'b0);
    $display("t_readback done");
  endtask : t_readback
  // strobe rises on a misaligned frame, one more bit then aligns it
  task t_reload;
    i_ads_host_model.shift({4'hF, `ADS_ID_HIGH, 1'b0, 6'h18, 1'b1}, 15);
    i_ads_host_model.latch(1'b1);
    chk(delay_select_bits, 6'h2D);
    i_ads_host_model.shift(16'h8000, 1);
    i_ads_host_model.latch(1'b0);
    @(negedge aclk);
    chk({ack_readback_pin, mute_out, delay_select_bits}, {2'h3, 6'h18});
    $display("t_reload done");
  endtask : t_reload
  task t_axi;
    axi_rd(`ADS_REG_STATUS);
    chk({r, d[7:0]}, {`ADS_RESP_OKAY, 1'b0, 6'h18, 1'b1});
    axi_rd(`ADS_REG_DELAY);
    chk(d, 32'h1900);
    axi_rd(`ADS_REG_POINTERS);
    chk(d[29:16], 14'(d[13:0] - 14'h1900));
    send(`ADS_ID_HIGH, 1'b0, 6'h18, 1'b0);
    axi_wr(`ADS_REG_CONTROL, 32'h1);
    @(negedge aclk);
    chk({r, mute_out}, {`ADS_RESP_OKAY, 1'b1});
    axi_rd(`ADS_REG_CONTROL);
    chk(d[0], 1'b1);
    axi_wr(`ADS_REG_CONTROL, 32'h0);
    axi_rd(4'h2);
    chk({r, mute_out}, {`ADS_RESP_SLVERR, 1'b0});
    $display("t_axi done");
  endtask : t_axi
  initial begin
    n_mismatch = 0;
    n_compared = 0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, address_select_pin} = 6'h0;
    {awaddr, araddr, wstrb, wdata} = 44'h00F_0000_0000;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1; // host sends nothing during the power-on hold
    t_defaults;
    t_ids;
    t_sleep;
    t_readback;
    t_reload;
    t_axi;
    test_done;
  end
  initial begin
    repeat (40000) @(posedge aclk);
    n_mismatch++;
    $display("watchdog expired");
    test_done;
  end
endmodule : audio_delay_serial_control_test
